// [inc/rtcta_pkg.sv]
// Purpose: shared constants for the trim and alarm block
// Assumes: 100 MHz system clock
// Notes:   register offsets are 4-bit serial addresses
package rtcta_pkg;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [3:0] ADDR_TRIM  = 4'h7;
  localparam logic [3:0] ADDR_WMIN  = 4'h8;
  localparam logic [3:0] ADDR_WHOUR = 4'h9;
  localparam logic [3:0] ADDR_WDAYS = 4'hA;
  localparam logic [3:0] ADDR_DMIN  = 4'hB;
  localparam logic [3:0] ADDR_DHOUR = 4'hC;
  localparam logic [7:0] TRIM_RST   = 8'h00;
  localparam logic [7:0] ALARM_RST  = 8'h00;
  localparam logic [7:0] MIN_MASK   = 8'h7F;
  localparam logic [7:0] HOUR_MASK  = 8'h3F;
  localparam logic [7:0] DAYS_MASK  = 8'h7F;
  localparam int         TRIM_SEL_BIT = 7;
  localparam int         TRIM_DIR_BIT = 6;
  // ----------------------------------------
  // timekeeping
  // ----------------------------------------
  localparam int          CNT_W         = 16;
  localparam logic [15:0] NOMINAL_COUNT = 16'h8000;
  localparam logic [15:0] TRIM_OFFSET   = 16'h0002;
  localparam logic [7:0]  SEC_LAST      = 8'h59;
  localparam logic [7:0]  SEC_00        = 8'h00;
  localparam logic [7:0]  SEC_20        = 8'h20;
  localparam logic [7:0]  SEC_40        = 8'h40;
  localparam int          CLK_PERIOD_NS  = 10;
  localparam int          ALARM_DELAY_NS = 61000;
  localparam int          ALARM_DELAY_CYC = ALARM_DELAY_NS / CLK_PERIOD_NS;
  // ----------------------------------------
  // serial command
  // ----------------------------------------
  localparam int         FMT_ONE_BIT  = 3;
  localparam int         FMT_READ_BIT = 2;
  localparam logic [2:0] BIT_LAST     = 3'h7;
  typedef enum logic [1:0] {
    SER_IDLE = 2'b00,
    SER_CMD  = 2'b01,
    SER_DATA = 2'b10
  } rtcta_ser_state_t;
endpackage : rtcta_pkg

// [design/rtcta_prescaler.sv]
// Purpose: one-second divider with per-second terminal count
// Assumes: osc_tick_in is a one-cycle pulse per crystal period
// Notes:   next_count_in is taken on the wrap cycle
`timescale 1ns/1ns
module rtcta_prescaler #(
  parameter int CNT_W = rtcta_pkg::CNT_W
) (
  input  wire logic             mclk_in,
  input  wire logic             rst_n_in,
  input  wire logic             osc_tick_in,
  input  wire logic [CNT_W-1:0] next_count_in,
  output logic                  sec_tick_out,
  output logic [CNT_W-1:0]      tc_out
);
  import rtcta_pkg::*;

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] tc_q;
  logic             wrap;

  assign wrap = osc_tick_in && (cnt_q == tc_q - CNT_W'(1));
  assign sec_tick_out = wrap;
  assign tc_out = tc_q;

  // ----------------------------------------
  // divider
  // ----------------------------------------
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_q <= '0;
      tc_q  <= CNT_W'(NOMINAL_COUNT);
    end else if (wrap) begin
      cnt_q <= '0;
      tc_q  <= next_count_in; // [RL22]
    end else if (osc_tick_in) begin
      cnt_q <= cnt_q + CNT_W'(1);
    end
  end

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  chk_count_range: assert property (cnt_q < tc_q) // [RL8]
    else $error("prescaler count beyond terminal");
  chk_wrap_restart: assert property (wrap |=> cnt_q == '0 && tc_q == $past(next_count_in)) // [RL22]
    else $error("prescaler did not restart");
endmodule : rtcta_prescaler

// [design/rtcta_serial.sv]
// Purpose: three-wire serial register port
// Assumes: ce, sclk, sio synchronous to mclk_in
// Notes:   edge polarity chosen by sclk level at ce rise
`timescale 1ns/1ns
module rtcta_serial (
  input  wire logic       mclk_in,
  input  wire logic       rst_n_in,
  input  wire logic       ce_in,
  input  wire logic       sclk_in,
  input  wire logic       sio_in,
  input  wire logic [7:0] rdata_in,
  output logic [3:0]      addr_out,
  output logic            wr_stb_out,
  output logic [7:0]      wdata_out,
  output logic            sio_out,
  output logic            sio_oe_n_out
);
  import rtcta_pkg::*;

  rtcta_ser_state_t state_q;
  logic       sclk_q;
  logic       mode_q;
  logic       rd_q;
  logic       one_q;
  logic [2:0] bit_q;
  logic [7:0] sh_q;
  logic [6:0] tx_q;
  logic       smp;
  logic       drv;
  logic [7:0] byte_in;

  // mode 1: sample on rising sclk, drive on falling
  assign smp = ce_in && (mode_q ? (sclk_in && !sclk_q) : (!sclk_in && sclk_q));
  assign drv = ce_in && (mode_q ? (!sclk_in && sclk_q) : (sclk_in && !sclk_q));
  assign byte_in = {sh_q[6:0], sio_in};

  // ----------------------------------------
  // receive side
  // ----------------------------------------
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q    <= SER_IDLE;
      sclk_q     <= 1'b0;
      mode_q     <= 1'b0;
      rd_q       <= 1'b0;
      one_q      <= 1'b0;
      bit_q      <= 3'h0;
      sh_q       <= 8'h00;
      addr_out   <= 4'h0;
      wr_stb_out <= 1'b0;
      wdata_out  <= 8'h00;
    end else begin
      sclk_q     <= sclk_in;
      wr_stb_out <= 1'b0;
      if (!ce_in) begin
        state_q <= SER_IDLE;
      end else begin
        case (state_q)
          SER_IDLE: begin
            state_q <= SER_CMD;
            mode_q  <= sclk_in;
            bit_q   <= 3'h0;
          end
          SER_CMD: if (smp) begin
            sh_q  <= byte_in;
            bit_q <= bit_q + 3'h1;
            if (bit_q == BIT_LAST) begin
              addr_out <= byte_in[7:4];
              rd_q     <= byte_in[FMT_READ_BIT];
              one_q    <= byte_in[FMT_ONE_BIT];
              state_q  <= SER_DATA;
            end
          end
          SER_DATA: if (smp) begin
            sh_q  <= byte_in;
            bit_q <= bit_q + 3'h1;
            if (bit_q == BIT_LAST) begin
              if (!rd_q) begin
                wr_stb_out <= 1'b1;
                wdata_out  <= byte_in;
              end
              // 4-bit pointer wraps from the top address to zero
              if (one_q) state_q <= SER_CMD;
              else addr_out <= addr_out + 4'h1;
            end
          end
          default: state_q <= SER_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------
  // transmit side
  // ----------------------------------------
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sio_out      <= 1'b0;
      sio_oe_n_out <= 1'b1;
      tx_q         <= 7'h00;
    end else if (!(state_q == SER_DATA && rd_q && ce_in)) begin
      sio_oe_n_out <= 1'b1;
    end else if (drv) begin
      sio_oe_n_out <= 1'b0;
      if (bit_q == 3'h0) begin
        sio_out <= rdata_in[7];
        tx_q    <= rdata_in[6:0];
      end else begin
        sio_out <= tx_q[6];
        tx_q    <= {tx_q[5:0], 1'b0};
      end
    end
  end

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  chk_release_idle: assert property (!ce_in |=> sio_oe_n_out)
    else $error("sio driven without chip enable");
  chk_strobe_pulse: assert property (wr_stb_out |=> !wr_stb_out)
    else $error("write strobe longer than one cycle");
  cov_write: cover property (wr_stb_out);
  cov_read:  cover property ($fell(sio_oe_n_out));
endmodule : rtcta_serial

// [design/rtcta_top.sv]
// Purpose: time-count trim and alarm compare registers
// Assumes: rst_n_in marks power-up from 0 V; time inputs are BCD
// Notes:   minute/hour/weekday come from the calendar counters outside
//
// Contract
// [RL1] select bit 0: correct at seconds 00, 20 and 40
// [RL2] select bit 1: correct only at seconds 00
// [RL3] corrected second uses a trim-dependent oscillator count
// [RL4] a trim write skips the coinciding correction point
// [RL5] direction 0: lengthen by (magnitude minus one) times two
// [RL6] direction 1: shorten by (inverted magnitude plus one) times two
// [RL7] magnitude giving zero change leaves the second at nominal
// [RL8] plain second is 32768 counts, corrected is nominal plus adjustment
// [RL9] crystal clock output is untouched by trimming
// [RL10] weekly minute 8h, hour 9h, day mask Ah; unused bits read 0
// [RL11] hour bit 5 is pm flag or tens-of-twenty, stored as written
// [RL12] 12-hour codes 12 and 32 mean midnight and noon hours
// [RL13] each mask bit enables one weekday counter value 0 to 6
// [RL14] empty day mask never matches
// [RL15] host writes only existing times to alarm registers
// [RL16] daily minute at Bh, bit 7 reads 0
// [RL17] trim reads zero after power-up
// [RL18] enabled alarm sets flag about 61 us after match, interrupt low
// [RL19] flags cleared by writing 0 only; clearing releases interrupt; here a low alarm enable also clears its flag
// [RL20] daily hour at Ch with weekly hour coding
// [RL21] weekly needs minute, hour, weekday; daily minute and hour only
// [RL22] correction loads an adjusted terminal count for one second
`timescale 1ns/1ns
module rtcta_top #(
  parameter int ALARM_DELAY_CYCLES = rtcta_pkg::ALARM_DELAY_CYC
) (
  input  wire logic       mclk_in,
  input  wire logic       rst_n_in,
  input  wire logic       osc_clk_in,
  input  wire logic       ce_in,
  input  wire logic       sclk_in,
  input  wire logic       sio_in,
  input  wire logic [7:0] cur_minute_in,
  input  wire logic [7:0] cur_hour_in,
  input  wire logic [2:0] weekday_counter_in,
  input  wire logic       weekly_alarm_en_in,
  input  wire logic       daily_alarm_en_in,
  input  wire logic       alarm_flag_wr_in,
  input  wire logic [1:0] alarm_flag_wdata_in,
  output logic            sio_out,
  output logic            sio_oe_n_out,
  output logic            clk32_out,
  output logic [7:0]      seconds_out,
  output logic            sec_tick_out,
  output logic            weekly_alarm_flag_out,
  output logic            daily_alarm_flag_out,
  output logic            interrupt_n_out
);
  import rtcta_pkg::*;

  localparam int DLY_W = $clog2(ALARM_DELAY_CYCLES + 1);
  localparam logic [DLY_W-1:0] DLY_LAST = DLY_W'(ALARM_DELAY_CYCLES - 1);

  logic [7:0]       time_trim_q;
  logic [7:0]       wmin_q;
  logic [7:0]       whour_q;
  logic [7:0]       wdays_q;
  logic [7:0]       dmin_q;
  logic [7:0]       dhour_q;
  logic [7:0]       sec_q;
  logic [7:0]       sec_next;
  logic             osc_q;
  logic             osc_tick;
  logic             trim_seen_q;
  logic [3:0]       addr;
  logic             wr_stb;
  logic [7:0]       wdata;
  logic [7:0]       rdata;
  logic             trim_wr;
  logic             skip;
  logic             boundary;
  logic             tick;
  logic [5:0]       trim_magnitude;
  logic             trim_direction;
  logic [15:0]      corr_count;
  logic [15:0]      next_count;
  logic [15:0]      tc;
  logic [1:0]       en;
  logic [1:0]       match;
  logic [1:0]       match_q;
  logic [1:0]       busy_q;
  logic [1:0]       set;
  logic [1:0]       flag_d;
  logic [1:0]       flag_q;
  logic [DLY_W-1:0] dly_q [2];

  // ----------------------------------------
  // serial port and register file
  // ----------------------------------------
  rtcta_serial u_serial (
    .mclk_in      (mclk_in),
    .rst_n_in     (rst_n_in),
    .ce_in        (ce_in),
    .sclk_in      (sclk_in),
    .sio_in       (sio_in),
    .rdata_in     (rdata),
    .addr_out     (addr),
    .wr_stb_out   (wr_stb),
    .wdata_out    (wdata),
    .sio_out      (sio_out),
    .sio_oe_n_out (sio_oe_n_out)
  );

  assign trim_wr = wr_stb && (addr == ADDR_TRIM);

  // alarm fields are undefined at power-up; zero keeps simulation clean
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      time_trim_q <= TRIM_RST; // [RL17]
      wmin_q      <= ALARM_RST;
      whour_q     <= ALARM_RST;
      wdays_q     <= ALARM_RST;
      dmin_q      <= ALARM_RST;
      dhour_q     <= ALARM_RST;
    end else if (wr_stb) begin
      case (addr)
        ADDR_TRIM:  time_trim_q <= wdata;
        ADDR_WMIN:  wmin_q      <= wdata & MIN_MASK;  // [RL10]
        ADDR_WHOUR: whour_q     <= wdata & HOUR_MASK; // [RL10] [RL11]
        ADDR_WDAYS: wdays_q     <= wdata & DAYS_MASK; // [RL10]
        ADDR_DMIN:  dmin_q      <= wdata & MIN_MASK;  // [RL16]
        ADDR_DHOUR: dhour_q     <= wdata & HOUR_MASK; // [RL20] [RL11]
        default:    ;
      endcase
    end
  end

  // other device registers sit outside this block and read zero here
  always_comb begin
    case (addr)
      ADDR_TRIM:  rdata = time_trim_q;
      ADDR_WMIN:  rdata = wmin_q;
      ADDR_WHOUR: rdata = whour_q;
      ADDR_WDAYS: rdata = wdays_q;
      ADDR_DMIN:  rdata = dmin_q;
      ADDR_DHOUR: rdata = dhour_q;
      default:    rdata = 8'h00;
    endcase
  end

  // ----------------------------------------
  // crystal clock and seconds
  // ----------------------------------------
  assign osc_tick = osc_clk_in && !osc_q;
  assign clk32_out = osc_q; // [RL9]
  assign seconds_out = sec_q;

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      osc_q <= 1'b0;
    end else begin
      osc_q <= osc_clk_in; // [RL9]
    end
  end

  always_comb begin
    if (sec_q == SEC_LAST) begin
      sec_next = SEC_00;
    end else if (sec_q[3:0] == 4'h9) begin
      sec_next = {sec_q[7:4] + 4'h1, 4'h0};
    end else begin
      sec_next = sec_q + 8'h01;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sec_q        <= SEC_00;
      sec_tick_out <= 1'b0;
    end else begin
      sec_tick_out <= tick;
      if (tick) sec_q <= sec_next;
    end
  end

  // ----------------------------------------
  // trim
  // ----------------------------------------
  assign trim_magnitude = time_trim_q[5:0];
  assign trim_direction = time_trim_q[TRIM_DIR_BIT];

  always_comb begin
    corr_count = NOMINAL_COUNT; // [RL7] [RL8]
    if (trim_magnitude != 6'h00) begin
      if (!trim_direction) begin
        corr_count = NOMINAL_COUNT + {9'h000, trim_magnitude, 1'b0} - TRIM_OFFSET; // [RL5]
      end else begin
        corr_count = NOMINAL_COUNT - {9'h000, ~trim_magnitude, 1'b0} - TRIM_OFFSET; // [RL6]
      end
    end
  end

  always_comb begin
    if (time_trim_q[TRIM_SEL_BIT]) begin
      boundary = (sec_next == SEC_00); // [RL2]
    end else begin
      boundary = (sec_next == SEC_00) || (sec_next == SEC_20) || (sec_next == SEC_40); // [RL1]
    end
  end

  // a write anywhere in the ending second, or on the tick itself, cancels
  assign skip = trim_wr || trim_seen_q; // [RL4]
  assign next_count = (boundary && !skip) ? corr_count : NOMINAL_COUNT; // [RL3]

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      trim_seen_q <= 1'b0;
    end else if (tick) begin
      trim_seen_q <= 1'b0;
    end else if (trim_wr) begin
      trim_seen_q <= 1'b1; // [RL4]
    end
  end

  rtcta_prescaler #(
    .CNT_W (CNT_W)
  ) u_prescaler (
    .mclk_in       (mclk_in),
    .rst_n_in      (rst_n_in),
    .osc_tick_in   (osc_tick),
    .next_count_in (next_count),
    .sec_tick_out  (tick),
    .tc_out        (tc)
  );

  // ----------------------------------------
  // alarms: index 1 weekly, index 0 daily
  // ----------------------------------------
  assign en = {weekly_alarm_en_in, daily_alarm_en_in};
  // hour codes compared raw, so 12/32 and 24-hour coding need no mode
  assign match[1] = (cur_minute_in == wmin_q) && (cur_hour_in == whour_q)
                    && wdays_q[weekday_counter_in]; // [RL21] [RL13] [RL14] [RL12]
  assign match[0] = (cur_minute_in == dmin_q) && (cur_hour_in == dhour_q); // [RL21]

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      match_q <= 2'b00;
      busy_q  <= 2'b00;
      dly_q   <= '{default: '0};
    end else begin
      match_q <= match;
      for (int i = 0; i < 2; i++) begin
        if (!en[i]) begin
          busy_q[i] <= 1'b0;
          dly_q[i]  <= '0;
        end else if (match[i] && !match_q[i]) begin
          busy_q[i] <= 1'b1; // [RL18]
          dly_q[i]  <= '0;
        end else if (busy_q[i]) begin
          if (dly_q[i] == DLY_LAST) busy_q[i] <= 1'b0;
          else dly_q[i] <= dly_q[i] + DLY_W'(1);
        end
      end
    end
  end

  // a set in the clearing cycle wins over the clear
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      set[i] = en[i] && busy_q[i] && (dly_q[i] == DLY_LAST);
      if (!en[i]) flag_d[i] = 1'b0;
      else if (set[i]) flag_d[i] = 1'b1; // [RL18]
      else if (alarm_flag_wr_in && !alarm_flag_wdata_in[i]) flag_d[i] = 1'b0; // [RL19]
      else flag_d[i] = flag_q[i];
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      flag_q          <= 2'b00;
      interrupt_n_out <= 1'b1;
    end else begin
      flag_q          <= flag_d;
      interrupt_n_out <= ~|flag_d; // [RL18] [RL19]
    end
  end

  assign weekly_alarm_flag_out = flag_q[1];
  assign daily_alarm_flag_out  = flag_q[0];

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  chk_twenty_point: assert property (tick && !time_trim_q[7] && sec_q == 8'h19 && !skip // [RL1]
    |=> tc == $past(corr_count)) else $error("no correction at second 20");
  chk_minute_only: assert property (tick && time_trim_q[7] && sec_q != 8'h59 // [RL2]
    |=> tc == 16'h8000) else $error("correction off the minute");
  chk_skip_write: assert property (tick && trim_wr |=> tc == 16'h8000) // [RL4]
    else $error("correction not skipped on write");
  chk_inc_amount: assert property (!time_trim_q[6] && time_trim_q[5:0] > 6'h01 // [RL5]
    |-> corr_count == 16'h8000 + 16'(2 * (time_trim_q[5:0] - 6'h01)))
    else $error("wrong lengthening");
  chk_dec_amount: assert property (time_trim_q[6] && time_trim_q[5:0] != 6'h00 // [RL6]
    |-> corr_count == 16'h8000 - 16'(2 * (7'h40 - {1'b0, time_trim_q[5:0]})))
    else $error("wrong shortening");
  chk_zero_change: assert property (time_trim_q[5:0] == 6'h00 |-> corr_count == 16'h8000) // [RL7]
    else $error("zero magnitude changed count");
  chk_clk_passthru: assert property (clk32_out == $past(osc_clk_in)) // [RL9]
    else $error("clock output altered");
  chk_empty_mask: assert property (wdays_q[6:0] == 7'h00 |-> !match[1]) // [RL14]
    else $error("weekly match with empty mask");
  chk_flag_wait: assert property ($rose(flag_q[1]) |-> $past(busy_q[1], 1)) // [RL18]
    else $error("weekly flag without delay");
  chk_flag_clear: assert property (alarm_flag_wr_in && !alarm_flag_wdata_in[1] && !set[1] // [RL19]
    |=> !flag_q[1]) else $error("weekly flag not cleared");
  chk_one_noop: assert property (flag_q[0] && en[0] && alarm_flag_wr_in // [RL19]
    && alarm_flag_wdata_in[0] |=> flag_q[0]) else $error("writing one cleared flag");
  chk_int_level: assert property (interrupt_n_out == !(|flag_q)) // [RL19]
    else $error("interrupt disagrees with flags");
  cov_corrected: cover property (tick && next_count != 16'h8000);
  cov_weekly_flag: cover property ($rose(flag_q[1]));
  cov_trim_write: cover property (trim_wr);
endmodule : rtcta_top

// [verification/rtcta_host_model.sv]
// Purpose: host side of the three-wire serial register port
// Assumes: sclk rests at idle_q; the device samples sio on the return to idle
// Notes:   every sclk level is held 3 mclk cycles, above the 2 asked for
`timescale 1ns/1ns
module rtcta_host_model (
  input  wire logic mclk_in,
  input  wire logic sio_in,
  output logic      ce_out,
  output logic      sclk_out,
  output logic      sio_out
);
  logic sio_q;
  logic drive_q;
  logic idle_q;
  // released line shows the inverse of the last bit, never a stale copy
  assign sio_out = drive_q ? sio_q : ~sio_q;
  initial begin
    ce_out   = 1'b0;
    sclk_out = 1'b0;
    sio_q    = 1'b0;
    drive_q  = 1'b0;
    idle_q   = 1'b0;
  end
  // sclk level at the ce rise picks the device's edge pairing
  task automatic set_mode(input logic idle);
    idle_q   = idle;
    sclk_out = idle;
    hold();
  endtask : set_mode
  task automatic hold();
    repeat (3) @(posedge mclk_in);
    #1;
  endtask : hold
  task automatic shift_byte(input logic [7:0] b);
    drive_q = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      sio_q    = b[i];
      sclk_out = ~idle_q;
      hold();
      sclk_out = idle_q;
      hold();
    end
    drive_q = 1'b0;
  endtask : shift_byte
  // callers hand over only existing times for alarm fields, except the FFh mask writes in test_regs
  task automatic write_reg(input logic [3:0] a, input logic [7:0] d);
    ce_out = 1'b1;
    hold();
    shift_byte({a, 4'h8});
    shift_byte(d);
    ce_out = 1'b0;
    hold();
  endtask : write_reg
  task automatic read_reg(input logic [3:0] a, output logic [7:0] d);
    ce_out = 1'b1;
    hold();
    shift_byte({a, 4'hC});
    for (int i = 7; i >= 0; i--) begin
      sclk_out = ~idle_q;
      hold();
      d[i]     = sio_in;
      sclk_out = idle_q;
      hold();
    end
    ce_out = 1'b0;
    hold();
  endtask : read_reg
endmodule : rtcta_host_model

// [verification/test_rtc_trim_and_alarm_regs.sv]
// Purpose: self-checking bench for the trim and alarm block
// Assumes: alarm delay shortened to 4 cycles
// Notes:   one whole second is pulsed out; trim boundaries lie too far off
`timescale 1ns/1ns
module test_rtc_trim_and_alarm_regs;
  import rtcta_pkg::*;
  logic       mclk, rst_n, osc, ce, sclk, host_sio, sio_line, dut_sio, oe_n;
  logic       clk32, tick, w_en, d_en, fl_wr, w_flag, d_flag, int_n;
  logic [7:0] cur_min, cur_hour, secs, rd;
  logic [2:0] wday;
  logic [1:0] fl_wd;
  int         bad_count, compares, ticks;
  // ------------------------------
  // structure
  // ------------------------------
  assign sio_line = oe_n ? host_sio : dut_sio;
  rtcta_top #(.ALARM_DELAY_CYCLES(4)) rtcta_top_i (
    .mclk_in(mclk), .rst_n_in(rst_n), .osc_clk_in(osc), .ce_in(ce), .sclk_in(sclk),
    .sio_in(sio_line), .cur_minute_in(cur_min), .cur_hour_in(cur_hour),
    .weekday_counter_in(wday), .weekly_alarm_en_in(w_en), .daily_alarm_en_in(d_en),
    .alarm_flag_wr_in(fl_wr), .alarm_flag_wdata_in(fl_wd), .sio_out(dut_sio),
    .sio_oe_n_out(oe_n), .clk32_out(clk32), .seconds_out(secs), .sec_tick_out(tick),
    .weekly_alarm_flag_out(w_flag), .daily_alarm_flag_out(d_flag),
    .interrupt_n_out(int_n));
  rtcta_host_model rtcta_host_model_i (
    .mclk_in(mclk), .sio_in(sio_line), .ce_out(ce), .sclk_out(sclk), .sio_out(host_sio));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) if (tick === 1'b1) ticks <= ticks + 1;
  // ------------------------------
  // helpers
  // ------------------------------
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc
  task automatic flag_write(input logic [1:0] v);
    fl_wd = v;
    fl_wr = 1'b1;
    cyc(1);
    fl_wr = 1'b0;
    cyc(2);
  endtask : flag_write
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish
  // ------------------------------
  // scenarios
  // ------------------------------
  task automatic test_second();
    for (int i = 0; i < 32767; i++) begin
      osc = 1'b1;
      cyc(1);
      osc = 1'b0;
      cyc(1);
    end
    cyc(8);
    check("ticks_short", 8'(ticks), 8'h00);
    osc = 1'b1;
    cyc(8);
    check("clk32", {7'h00, clk32}, 8'h01);
    check("ticks_full", 8'(ticks), 8'h01);
    check("seconds", secs, 8'h01);
    osc = 1'b0;
    $display("test second_length done");
  endtask : test_second
  task automatic test_regs();
    logic [3:0] a [5] = '{ADDR_TRIM, ADDR_WMIN, ADDR_WHOUR, ADDR_WDAYS, ADDR_DMIN};
    logic [7:0] e [5] = '{8'hFF, 8'h7F, 8'h3F, 8'h7F, 8'h7F};
    rtcta_host_model_i.read_reg(ADDR_TRIM, rd);
    check("trim_reset", rd, 8'h00);
    rtcta_host_model_i.read_reg(4'h3, rd);
    check("unmapped", rd, 8'h00);
    rtcta_host_model_i.set_mode(1'b1);
    rtcta_host_model_i.write_reg(ADDR_TRIM, 8'h07);
    rtcta_host_model_i.read_reg(ADDR_TRIM, rd);
    check("trim_mode1", rd, 8'h07);
    check("lengthen_hi", rtcta_top_i.corr_count[15:8], 8'h80);
    check("lengthen_lo", rtcta_top_i.corr_count[7:0], 8'h0C);
    rtcta_host_model_i.set_mode(1'b0);
    foreach (a[i]) begin
      rtcta_host_model_i.write_reg(a[i], 8'hFF);
      rtcta_host_model_i.read_reg(a[i], rd);
      check("reg_mask", rd, e[i]);
    end
    check("shorten_hi", rtcta_top_i.corr_count[15:8], 8'h7F);
    check("shorten_lo", rtcta_top_i.corr_count[7:0], 8'hFE);
    $display("test registers done");
  endtask : test_regs
  task automatic alarm_case(input logic [7:0] mn, input logic [7:0] hr,
                            input logic [7:0] days, input logic [2:0] wd,
                            input logic ew, input logic ed);
    w_en    = 1'b0;
    d_en    = 1'b0;
    cur_min = 8'h31;
    rtcta_host_model_i.write_reg(ADDR_WMIN, mn);
    rtcta_host_model_i.write_reg(ADDR_WHOUR, hr);
    rtcta_host_model_i.write_reg(ADDR_WDAYS, days);
    rtcta_host_model_i.write_reg(ADDR_DMIN, mn);
    rtcta_host_model_i.write_reg(ADDR_DHOUR, hr);
    wday = wd;
    w_en = 1'b1;
    d_en = 1'b1;
    cyc(2);
    cur_min  = mn;
    cur_hour = hr;
    cyc(3);
    check("early_flags", {6'h00, w_flag, d_flag}, 8'h00);
    cyc(5);
    check("flags", {6'h00, w_flag, d_flag}, {6'h00, ew, ed});
    check("interrupt_n", {7'h00, int_n}, {7'h00, ~(ew | ed)});
  endtask : alarm_case
  task automatic test_alarms();
    alarm_case(8'h30, 8'h32, 8'h04, 3'h2, 1'b1, 1'b1);
    flag_write(2'b11);
    check("flag_hold", {7'h00, w_flag}, 8'h01);
    flag_write(2'b00);
    check("flag_clear", {6'h00, w_flag, d_flag}, 8'h00);
    check("int_release", {7'h00, int_n}, 8'h01);
    alarm_case(8'h30, 8'h32, 8'h04, 3'h3, 1'b0, 1'b1);
    alarm_case(8'h15, 8'h12, 8'h00, 3'h2, 1'b0, 1'b1);
    alarm_case(8'h59, 8'h23, 8'h40, 3'h6, 1'b1, 1'b1);
    rtcta_host_model_i.read_reg(ADDR_WHOUR, rd);
    check("hour_code", rd, 8'h23);
    $display("test alarms done");
  endtask : test_alarms
  // ------------------------------
  // run and watchdog
  // ------------------------------
  initial begin
    rst_n    = 1'b0;
    osc      = 1'b0;
    cur_min  = 8'h31;
    cur_hour = 8'h00;
    wday     = 3'h0;
    w_en     = 1'b0;
    d_en     = 1'b0;
    fl_wr    = 1'b0;
    fl_wd    = 2'b11;
    cyc(8);
    rst_n = 1'b1;
    cyc(1);
    test_regs();
    test_second();
    test_alarms();
    tally_and_finish();
  end
  // whole run is near 69k cycles; 100k leaves margin
  initial begin
    repeat (100000) @(posedge mclk);
    bad_count++;
    tally_and_finish();
  end
endmodule : test_rtc_trim_and_alarm_regs
